// ===== logic/pfc_pause_map.svh
// Offsets, field positions, reset values and timing counts of the pause block.
//
// Overview of operation
// - Receive enable gates only user-side pause reporting.
// - Transmit enable blocks pause packets per index.
// - Each request bit sends its pause packet.
// - Resend repeats requested packets, resets refresh counters.
// - Nine transmit quanta; entry eight is global.
// - Nine refresh intervals; entry eight is global.
// - Global packets use their own header fields.
// - Priority packets use separate header fields.
// - Sent-pause bit n marks packet sent.
// - Acknowledge bus used only when checking enabled.
// - Global control class has enable and checks.
// - Global control opcode must lie in range.
// - Priority control class has own checks.
// - Global pause opcode compared for equality.
// - Priority pause class has own checks.
// - All classes share three address compare values.
// - Forward control input passes or drops packets.
// - Received pause sets matching valid bit.
// - Received quanta shown per index; global eight.
// - Pause request held until processing finishes.
// - Snapshot tick from pin or register write.
`ifndef PFC_PAUSE_MAP_SVH
`define PFC_PAUSE_MAP_SVH

// ==========================================================================
// Register word indices (byte address is four times the index).
`define PFC_NCFG 64
`define PFC_IDX_TXEN 0
`define PFC_IDX_TXREQ 1
`define PFC_IDX_RXCTL 2
`define PFC_IDX_RXCHK 3
`define PFC_IDX_CMD 4
`define PFC_IDX_STATUS 5
`define PFC_IDX_TX_GDA 6
`define PFC_IDX_TX_GSA 8
`define PFC_IDX_TX_PDA 10
`define PFC_IDX_TX_PSA 12
`define PFC_IDX_TX_GTYP 14
`define PFC_IDX_TX_PTYP 15
`define PFC_IDX_RX_UC 16
`define PFC_IDX_RX_MC 18
`define PFC_IDX_RX_SA 20
`define PFC_IDX_RX_CTYP 22
`define PFC_IDX_RX_GCOP 23
`define PFC_IDX_RX_PCOP 24
`define PFC_IDX_RX_GTYP 25
`define PFC_IDX_RX_PTYP 26
`define PFC_IDX_LAST_LO 26
`define PFC_IDX_QUANTA 32
`define PFC_IDX_REFRESH 48
`define PFC_CFG_RST 32'h0000_0000

// ==========================================================================
// Field positions.
`define PFC_RXCTL_CHKACK 9
`define PFC_RXCTL_FWD 10
`define PFC_RXCTL_TSEL 11
`define PFC_CMD_RESEND 0
`define PFC_CMD_TICK 1
`define PFC_STAT_BUSY 15
`define PFC_CHK_EN 0
`define PFC_CHK_MC 1
`define PFC_CHK_UC 2
`define PFC_CHK_SA 3
`define PFC_CHK_ET 4
`define PFC_CHK_OP 5

// ==========================================================================
// Timing: one pause quantum is 512 bit times at 10 Gb/s.
`define PFC_CLK_PERIOD_PS 100000
`define PFC_QUANTUM_PS 51200
`define PFC_QUANTUM_CYC ((`PFC_QUANTUM_PS+`PFC_CLK_PERIOD_PS-1)/`PFC_CLK_PERIOD_PS)

`endif

// ===== logic/pfc_pkg.sv
// Types shared by the pause flow control block.
`default_nettype none
package pfc_pkg;
  typedef logic [8:0][15:0] pfc_q9_t;

  // Parsed header of a received frame, valid for one cycle.
  typedef struct packed {
    logic valid;
    logic [47:0] da;
    logic [47:0] sa;
    logic [15:0] etype;
    logic [15:0] opcode;
    logic [7:0] pev;
    logic [7:0][15:0] quanta;
  } pfc_rx_hdr_t;

  // Pause packet descriptor handed to the transmit datapath.
  typedef struct packed {
    logic valid;
    logic global_pkt;
    logic [8:0] mask;
    logic [47:0] da;
    logic [47:0] sa;
    logic [15:0] etype;
    logic [15:0] opcode;
    logic [7:0] pev;
    pfc_q9_t quanta;
  } pfc_tx_pkt_t;

  // Whole state of the block.
  typedef struct packed {
    logic [63:0][31:0] cfg;
    logic ack;
    logic [31:0] dat;
    logic [15:0] qcnt;
    logic [8:0] pend;
    logic [8:0] req_q;
    logic busy;
    logic [8:0] sent;
    pfc_q9_t tmr;
    pfc_q9_t rtmr;
    logic [8:0] rreq;
    pfc_q9_t rxq;
    logic [8:0] rx_valid;
    logic [8:0] rx_req;
    logic [8:0] xoff;
    logic fwd;
    logic drop;
    logic snap;
    pfc_tx_pkt_t tx;
  } pfc_state_t;
endpackage : pfc_pkg
`default_nettype wire

// ===== logic/pfc_pause_flow_control.sv
// Pause and priority flow control engine with a Wishbone register slave.
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pfc_pause_map.svh"

module pfc_pause_flow_control #(
  parameter int unsigned QUANTUM_CYC = `PFC_QUANTUM_CYC
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire pfc_pkg::pfc_rx_hdr_t rx_hdr_i,
  input wire logic [8:0] rx_pause_ack_i,
  input wire logic tx_done_i,
  input wire logic counter_snapshot_tick,
  output pfc_pkg::pfc_tx_pkt_t tx_pkt_o,
  output logic [8:0] tx_pause_sent_o,
  output logic [8:0] rx_pause_valid_o,
  output pfc_pkg::pfc_q9_t rx_pause_quanta_o,
  output logic [8:0] rx_pause_req_o,
  output logic [8:0] mac_xoff_o,
  output logic rx_ctl_forward_o,
  output logic rx_ctl_drop_o,
  output logic snapshot_tick_o
);

  // ========================================================================
  // Helper functions.

  // A word that is not listed reads as zero and ignores writes.
  function automatic logic pfc_mapped(input logic [5:0] idx);
    return (idx <= 6'(`PFC_IDX_LAST_LO)) ||
           (idx >= 6'(`PFC_IDX_QUANTA) && idx <= 6'(`PFC_IDX_QUANTA + 8)) ||
           (idx >= 6'(`PFC_IDX_REFRESH) && idx <= 6'(`PFC_IDX_REFRESH + 8));
  endfunction : pfc_mapped

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] pfc_merge(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction : pfc_merge

  // A 48-bit address is held in a low word and the low half of the next.
  function automatic logic [47:0] pfc_addr(input logic [31:0] lo,
                                          input logic [31:0] hi);
    return {hi[15:0], lo};
  endfunction : pfc_addr

  // Classifier shared by all four receive classes.
  function automatic logic pfc_class_pass(input logic [5:0] chk,
                                         input pfc_pkg::pfc_rx_hdr_t h,
                                         input logic [47:0] uc,
                                         input logic [47:0] mc,
                                         input logic [47:0] sa,
                                         input logic [15:0] et,
                                         input logic [15:0] omin,
                                         input logic [15:0] omax);
    logic da_ok;
    logic sa_ok;
    logic et_ok;
    logic op_ok;
    // With both address checks on, either destination match is enough.
    da_ok = !(chk[`PFC_CHK_MC] || chk[`PFC_CHK_UC]) ||
            (chk[`PFC_CHK_MC] && h.da == mc) ||
            (chk[`PFC_CHK_UC] && h.da == uc);
    sa_ok = !chk[`PFC_CHK_SA] || h.sa == sa;
    et_ok = !chk[`PFC_CHK_ET] || h.etype == et;
    op_ok = !chk[`PFC_CHK_OP] || (h.opcode >= omin && h.opcode <= omax);
    return chk[`PFC_CHK_EN] && da_ok && sa_ok && et_ok && op_ok;
  endfunction : pfc_class_pass

  // ========================================================================
  // State.

  pfc_pkg::pfc_state_t s_r;
  pfc_pkg::pfc_state_t s_nxt;

  // Decoded configuration, read from the stored words.
  logic [8:0] tx_en;
  logic [8:0] tx_req;
  logic [8:0] rx_en;
  logic [23:0] rx_chk;
  logic chk_ack;
  logic fwd_ctl;
  logic tick_sel;
  logic [47:0] rx_uc;
  logic [47:0] rx_mc;
  logic [47:0] rx_sa;

  // Field extraction groups.
  assign tx_en = s_r.cfg[`PFC_IDX_TXEN][8:0];
  assign tx_req = s_r.cfg[`PFC_IDX_TXREQ][8:0];
  assign rx_en = s_r.cfg[`PFC_IDX_RXCTL][8:0];
  assign chk_ack = s_r.cfg[`PFC_IDX_RXCTL][`PFC_RXCTL_CHKACK];
  assign fwd_ctl = s_r.cfg[`PFC_IDX_RXCTL][`PFC_RXCTL_FWD];
  assign tick_sel = s_r.cfg[`PFC_IDX_RXCTL][`PFC_RXCTL_TSEL];
  assign rx_chk = s_r.cfg[`PFC_IDX_RXCHK][23:0];
  assign rx_uc = pfc_addr(s_r.cfg[`PFC_IDX_RX_UC], s_r.cfg[`PFC_IDX_RX_UC + 1]);
  assign rx_mc = pfc_addr(s_r.cfg[`PFC_IDX_RX_MC], s_r.cfg[`PFC_IDX_RX_MC + 1]);
  assign rx_sa = pfc_addr(s_r.cfg[`PFC_IDX_RX_SA], s_r.cfg[`PFC_IDX_RX_SA + 1]);

  // ========================================================================
  // Next-state logic.

  // All behaviour lives in one process so that every flop has one driver.
  always_comb begin
    logic hit;
    logic [5:0] widx;
    logic resend_w;
    logic tick_w;
    logic qtick;
    logic [8:0] rise;
    logic [8:0] expire;
    logic [8:0] set;
    logic [8:0] launch;
    logic [15:0] refr;
    logic gcp_ok;
    logic pcp_ok;
    logic gpp_ok;
    logic ppp_ok;
    logic is_ctl;
    logic [8:0] hitm;
    logic [8:0] done;
    logic [15:0] rq;
    logic [31:0] ctyp;
    logic [31:0] gcop;
    logic [31:0] pcop;
    logic [31:0] gtyp;
    logic [31:0] ptyp;
    s_nxt = s_r;
    hit = 1'b0;
    widx = wb_adr_i[7:2];
    resend_w = 1'b0;
    tick_w = 1'b0;
    qtick = 1'b0;
    rise = '0;
    expire = '0;
    set = '0;
    launch = '0;
    refr = '0;
    hitm = '0;
    done = '0;
    rq = '0;
    ctyp = s_r.cfg[`PFC_IDX_RX_CTYP];
    gcop = s_r.cfg[`PFC_IDX_RX_GCOP];
    pcop = s_r.cfg[`PFC_IDX_RX_PCOP];
    gtyp = s_r.cfg[`PFC_IDX_RX_GTYP];
    ptyp = s_r.cfg[`PFC_IDX_RX_PTYP];

    // Wishbone slave: one wait state, ack for a single cycle per request.
    hit = wb_cyc_i && wb_stb_i && !s_r.ack;
    s_nxt.ack = hit;
    s_nxt.dat = '0;
    if (hit && wb_we_i) begin
      if (widx == 6'(`PFC_IDX_CMD)) begin
        resend_w = wb_sel_i[0] && wb_dat_i[`PFC_CMD_RESEND];
        tick_w = wb_sel_i[0] && wb_dat_i[`PFC_CMD_TICK];
      end else if (pfc_mapped(widx) && widx != 6'(`PFC_IDX_STATUS)) begin
        s_nxt.cfg[widx] = pfc_merge(s_r.cfg[widx], wb_dat_i, wb_sel_i);
      end
    end else if (hit) begin
      if (widx == 6'(`PFC_IDX_STATUS)) begin
        s_nxt.dat = {7'h00, s_r.rreq, s_r.busy, 6'h00, s_r.pend};
      end else if (pfc_mapped(widx) && widx != 6'(`PFC_IDX_CMD)) begin
        s_nxt.dat = s_r.cfg[widx];
      end
    end

    // Pause quantum prescaler paces both refresh and receive timers.
    qtick = s_r.qcnt == 16'(QUANTUM_CYC - 1);
    s_nxt.qcnt = qtick ? 16'h0000 : s_r.qcnt + 16'h0001;

    // Transmit: new requests, refresh expiry and resend mark pending work.
    rise = tx_req & ~s_r.req_q;
    s_nxt.req_q = tx_req;
    for (int n = 0; n < 9; n++) begin
      refr = s_r.cfg[`PFC_IDX_REFRESH + n][15:0];
      expire[n] = tx_req[n] && refr != 16'h0000 &&
                  s_r.tmr[n] == 16'h0000;
    end
    // Resend relies on a one-cycle command write, so it cannot repeat.
    set = (rise | expire | ({9{resend_w}} & tx_req)) & tx_en;

    // Launch: global first, then all pending priorities in one frame.
    if (!s_r.busy) begin
      if (s_r.pend[8] && tx_en[8]) begin
        launch = 9'h100;
      end else begin
        launch = {1'b0, s_r.pend[7:0] & tx_en[7:0]};
      end
    end
    // A clear enable discards pending work; a new set beats the launch clear.
    s_nxt.pend = (s_r.pend & tx_en & ~launch) | set;

    // Refresh counters reload on launch, and on resend as well.
    for (int n = 0; n < 9; n++) begin
      refr = s_r.cfg[`PFC_IDX_REFRESH + n][15:0];
      if (resend_w || launch[n]) begin
        s_nxt.tmr[n] = refr;
      end else if (qtick && s_r.tmr[n] != 16'h0000) begin
        s_nxt.tmr[n] = s_r.tmr[n] - 16'h0001;
      end
    end

    // Build the descriptor; it stands until the datapath reports done.
    s_nxt.sent = '0;
    if (launch != 9'h000) begin
      s_nxt.busy = 1'b1;
      s_nxt.tx.valid = 1'b1;
      s_nxt.tx.mask = launch;
      s_nxt.tx.global_pkt = launch[8];
      s_nxt.tx.pev = launch[7:0];
      for (int n = 0; n < 9; n++) begin
        s_nxt.tx.quanta[n] = s_r.cfg[`PFC_IDX_QUANTA + n][15:0];
      end
      if (launch[8]) begin
        s_nxt.tx.da = pfc_addr(s_r.cfg[`PFC_IDX_TX_GDA],
                               s_r.cfg[`PFC_IDX_TX_GDA + 1]);
        s_nxt.tx.sa = pfc_addr(s_r.cfg[`PFC_IDX_TX_GSA],
                               s_r.cfg[`PFC_IDX_TX_GSA + 1]);
        s_nxt.tx.etype = s_r.cfg[`PFC_IDX_TX_GTYP][31:16];
        s_nxt.tx.opcode = s_r.cfg[`PFC_IDX_TX_GTYP][15:0];
      end else begin
        s_nxt.tx.da = pfc_addr(s_r.cfg[`PFC_IDX_TX_PDA],
                               s_r.cfg[`PFC_IDX_TX_PDA + 1]);
        s_nxt.tx.sa = pfc_addr(s_r.cfg[`PFC_IDX_TX_PSA],
                               s_r.cfg[`PFC_IDX_TX_PSA + 1]);
        s_nxt.tx.etype = s_r.cfg[`PFC_IDX_TX_PTYP][31:16];
        s_nxt.tx.opcode = s_r.cfg[`PFC_IDX_TX_PTYP][15:0];
      end
    end else if (s_r.busy && tx_done_i) begin
      s_nxt.busy = 1'b0;
      s_nxt.tx.valid = 1'b0;
      s_nxt.sent = s_r.tx.mask;
    end

    // Receive classification against the four programmed classes.
    gcp_ok = pfc_class_pass(rx_chk[5:0], rx_hdr_i, rx_uc, rx_mc, rx_sa,
                            ctyp[31:16], gcop[15:0], gcop[31:16]);
    pcp_ok = pfc_class_pass(rx_chk[11:6], rx_hdr_i, rx_uc, rx_mc, rx_sa,
                            ctyp[15:0], pcop[15:0], pcop[31:16]);
    gpp_ok = pfc_class_pass(rx_chk[17:12], rx_hdr_i, rx_uc, rx_mc, rx_sa,
                            gtyp[31:16], gtyp[15:0], gtyp[15:0]);
    ppp_ok = pfc_class_pass(rx_chk[23:18], rx_hdr_i, rx_uc, rx_mc, rx_sa,
                            ptyp[31:16], ptyp[15:0], ptyp[15:0]);
    is_ctl = rx_hdr_i.valid && (gcp_ok || pcp_ok || gpp_ok || ppp_ok);
    s_nxt.fwd = is_ctl && fwd_ctl;
    s_nxt.drop = is_ctl && !fwd_ctl;
    if (rx_hdr_i.valid && gpp_ok) begin
      hitm = 9'h100;
    end else if (rx_hdr_i.valid && ppp_ok) begin
      hitm = {1'b0, rx_hdr_i.pev};
    end

    // Internal processing runs on every hit, whatever the receive enable.
    for (int n = 0; n < 9; n++) begin
      rq = (n == 8) ? rx_hdr_i.quanta[0] : rx_hdr_i.quanta[n];
      if (hitm[n]) begin
        s_nxt.rtmr[n] = rq;
        if (rx_en[n]) begin
          s_nxt.rxq[n] = rq;
        end
      end else if (qtick && s_r.rtmr[n] != 16'h0000) begin
        s_nxt.rtmr[n] = s_r.rtmr[n] - 16'h0001;
      end
      // Ack is looked at only with checking on; else the quanta expiry ends it.
      done[n] = chk_ack ? rx_pause_ack_i[n] :
                          (s_r.rtmr[n] == 16'h0000);
      s_nxt.xoff[n] = s_nxt.rtmr[n] != 16'h0000;
    end
    // A new pause frame wins over a clear in the same cycle.
    s_nxt.rreq = (s_r.rreq & ~done) | hitm;
    s_nxt.rx_req = s_nxt.rreq & rx_en;
    s_nxt.rx_valid = hitm & rx_en;

    // Snapshot tick comes from the pin or from a command write.
    s_nxt.snap = tick_sel ? tick_w : counter_snapshot_tick;
  end

  // ========================================================================
  // State register.

  // Synchronous reset clears all configuration and control state.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ========================================================================
  // Outputs, each taken straight from the state register.
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;
  assign tx_pkt_o = s_r.tx;
  assign tx_pause_sent_o = s_r.sent;
  assign rx_pause_valid_o = s_r.rx_valid;
  assign rx_pause_quanta_o = s_r.rxq;
  assign rx_pause_req_o = s_r.rx_req;
  assign mac_xoff_o = s_r.xoff;
  assign rx_ctl_forward_o = s_r.fwd;
  assign rx_ctl_drop_o = s_r.drop;
  assign snapshot_tick_o = s_r.snap;

endmodule : pfc_pause_flow_control
`default_nettype wire

// ===== verification/pfc_user_model.sv
// Behavioural user flow-control logic and transmit datapath.
`timescale 1ns/1ns
`default_nettype none
module pfc_user_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic pkt_valid,
  input wire logic [8:0] pause_req,
  input wire logic [3:0] lat,
  output var logic tx_done = 1'b0,
  output var logic [8:0] pause_ack = 9'h000
);
  logic [3:0] tcnt_r;
  logic [3:0] acnt_r;
  // ====================
  // Packet completion
  // The packet in flight ends lat + 1 cycles after launch, so a slow far side
  // makes the block hold its descriptor longer.
  always @(posedge clock) begin
    tx_done <= rst_n && pkt_valid && !tx_done && tcnt_r == lat;
    if (!rst_n || !pkt_valid) begin
      tcnt_r <= 4'h0;
    end else if (!tx_done) begin
      tcnt_r <= tcnt_r + 4'h1;
    end
  end
  // All pending requests are acknowledged together lat + 1 cycles after the first one shows.
  always @(posedge clock) begin
    pause_ack <= 9'h000;
    if (!rst_n || pause_req == 9'h000) begin
      acnt_r <= 4'h0;
    end else begin
      acnt_r <= acnt_r + 4'h1;
      if (acnt_r == lat) begin
        pause_ack <= pause_req;
      end
    end
  end
endmodule : pfc_user_model
`default_nettype wire

// ===== verification/pfc_pause_flow_control_chk.sv
// Port timing checker of the pause flow control block.
`timescale 1ns/1ns
`default_nettype none
module pfc_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire pfc_pkg::pfc_rx_hdr_t rx_hdr_i,
  input wire logic tx_done_i,
  input wire pfc_pkg::pfc_tx_pkt_t tx_pkt_o,
  input wire logic [8:0] tx_pause_sent_o,
  input wire logic [8:0] rx_pause_valid_o,
  input wire pfc_pkg::pfc_q9_t rx_pause_quanta_o,
  input wire logic [8:0] rx_pause_req_o,
  input wire logic rx_ctl_forward_o,
  input wire logic rx_ctl_drop_o
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ====================
  // Bus and transmit side
  // A packet must not change while in flight, or the wire gets torn.
  wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o) else $error("bus answer wrong");
  sent_mask_a: assert property (
    tx_pkt_o.valid && tx_done_i |=> !tx_pkt_o.valid
    && tx_pause_sent_o == $past(tx_pkt_o.mask)) else $error("sent mask");
  sent_cause_a: assert property (
    tx_pause_sent_o != 9'h000 |-> $past(tx_done_i && tx_pkt_o.valid))
    else $error("sent without done");
  pkt_hold_a: assert property (
    tx_pkt_o.valid && !tx_done_i |=> tx_pkt_o.valid && $stable(tx_pkt_o))
    else $error("packet changed in flight");
  pkt_kind_a: assert property (
    tx_pkt_o.valid |-> tx_pkt_o.global_pkt == tx_pkt_o.mask[8]
    && tx_pkt_o.mask != 9'h000 && !(tx_pkt_o.mask[8] && |tx_pkt_o.mask[7:0]))
    else $error("packet kind wrong");
  // Receive side.
  rx_cause_a: assert property (
    rx_pause_valid_o != 9'h000 |-> $past(rx_hdr_i.valid))
    else $error("pause valid without frame");
  rx_global_a: assert property (
    rx_pause_valid_o[8] |-> rx_pause_req_o[8]
    && rx_pause_quanta_o[8] == $past(rx_hdr_i.quanta[0]))
    else $error("global quanta wrong");
  ctl_class_a: assert property (
    rx_ctl_forward_o || rx_ctl_drop_o |-> $past(rx_hdr_i.valid)
    && !(rx_ctl_forward_o && rx_ctl_drop_o)) else $error("control verdict");
endmodule : pfc_chk

bind pfc_pause_flow_control pfc_chk u_chk (.clock, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .rx_hdr_i, .tx_done_i, .tx_pkt_o, .tx_pause_sent_o,
  .rx_pause_valid_o, .rx_pause_quanta_o, .rx_pause_req_o, .rx_ctl_forward_o,
  .rx_ctl_drop_o);
`default_nettype wire

// ===== verification/pfc_pause_flow_control_bench.sv
// Self-checking bench of the pause flow control block.
`timescale 1ns/1ns
`default_nettype none
module pfc_pause_flow_control_bench;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rd;
  logic ack, done, pv, fwd, drp, snap;
  logic tick = 1'b0;
  logic [3:0] lat = 4'h1;
  logic [8:0] pack, sent, rxv, rxr, xoff;
  logic [31:0] v;
  logic [47:0] uc, gda, pda;
  logic [28:0] e;
  logic [15:0] qv [9];
  logic [31:0] rdq [$];
  logic [28:0] rxe [$];
  pfc_pkg::pfc_rx_hdr_t hdr = '0;
  pfc_pkg::pfc_tx_pkt_t pkt;
  pfc_pkg::pfc_q9_t rxq;
  int scnt [9] = '{default: 0};
  int nfwd = 0;
  int ndrp = 0;
  int nsnap = 0;
  int n;
  int failures = 0;
  int tests_run = 0;

  always #50 clock = ~clock;

  pfc_pause_flow_control #(.QUANTUM_CYC(1)) DUT (.clock, .rst_n,
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .rx_hdr_i(hdr), .rx_pause_ack_i(pack), .tx_done_i(done),
    .counter_snapshot_tick(tick), .tx_pkt_o(pkt), .tx_pause_sent_o(sent),
    .rx_pause_valid_o(rxv), .rx_pause_quanta_o(rxq), .rx_pause_req_o(rxr),
    .mac_xoff_o(xoff), .rx_ctl_forward_o(fwd), .rx_ctl_drop_o(drp),
    .snapshot_tick_o(snap));
  pfc_user_model PM (.clock, .rst_n, .pkt_valid(pkt.valid),
    .pause_req(rxr), .lat, .tx_done(done), .pause_ack(pack));

  // ====================
  // Shared tasks
  task automatic chk(string nm, logic [47:0] x, logic [47:0] s);
    tests_run++;
    if (s !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask : chk
  // One classic cycle; the request stands until ack is seen high.
  task automatic wb(logic w, logic [5:0] i, logic [31:0] d);
    @(posedge clock);
    cyc <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wd <= d;
    do @(posedge clock); while (ack !== 1'b1);
    cyc <= 1'b0;
  endtask : wb
  task automatic wbr(logic [5:0] i, logic [31:0] x);
    rdq.push_back(x);
    wb(1'b0, i, 32'h0000_0000);
  endtask : wbr
  task automatic rxf(logic [47:0] da, logic [15:0] op, logic [7:0] m,
                     logic [15:0] q);
    @(posedge clock);
    hdr.valid <= 1'b1;
    hdr.da <= da;
    hdr.etype <= 16'h8808;
    hdr.opcode <= op;
    hdr.pev <= m;
    hdr.quanta <= {8{q}};
    @(posedge clock);
    hdr.valid <= 1'b0;
  endtask : rxf
  // Bounded wait, so a lost packet shows as a short count.
  task automatic exp_sent(int i, int c);
    for (int k = 0; k < 80 && scnt[i] < c; k++) @(posedge clock);
    chk("sent count", c, scnt[i]);
  endtask : exp_sent
  task automatic pulse;
    @(posedge clock);
    tick <= 1'b1;
    @(posedge clock);
    tick <= 1'b0;
  endtask : pulse
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude

  // Each read and receive result is matched against the oldest note when it appears.
  always @(posedge clock) begin
    if (ack === 1'b1 && we === 1'b0)
      chk("read", rdq.size() ? rdq.pop_front() : 32'hffff_ffff, rd);
    if (rxv !== 9'h000) begin
      e = rxe.size() ? rxe.pop_front() : '1;
      chk("rx valid", e[24:16], rxv);
      chk("rx quanta", e[15:0], rxq[e[28:25]]);
    end
    if (pkt.valid === 1'b1 && pv !== 1'b1) begin
      chk("tx dest", pkt.mask[8] ? gda : pda, pkt.da);
      for (int k = 0; k < 9; k++)
        chk("tx quanta", qv[k], pkt.quanta[k]);
    end
    pv = pkt.valid;
    for (int k = 0; k < 9; k++)
      scnt[k] += (sent[k] === 1'b1);
    nfwd += (fwd === 1'b1);
    ndrp += (drp === 1'b1);
    nsnap += (snap === 1'b1);
  end

  // A hang counts as a mismatch.
  initial begin
    repeat (10000) @(posedge clock);
    failures++;
    $display("watchdog expired");
    conclude();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h4333));
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    wbr(6'd0, 32'h0000_0000);
    wbr(6'd48, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      v = $urandom;
      qv[i] = v[15:0];
      wb(1'b1, 6'(32 + i), v);
      wbr(6'(32 + i), v);
    end
    wb(1'b1, 6'd27, v);
    wbr(6'd27, 32'h0000_0000);
    wb(1'b1, 6'd5, v);
    wbr(6'd5, 32'h0000_0000);
    wbr(6'd4, 32'h0000_0000);
    $display("test registers done");
    gda = 48'({$urandom, $urandom});
    pda = 48'({$urandom, $urandom});
    wb(1'b1, 6'd6, gda[31:0]);
    wb(1'b1, 6'd7, {16'h0000, gda[47:32]});
    wb(1'b1, 6'd10, pda[31:0]);
    wb(1'b1, 6'd11, {16'h0000, pda[47:32]});
    lat <= 4'($urandom_range(4, 1));
    wb(1'b1, 6'd0, 32'h0000_01ff);
    wb(1'b1, 6'd1, 32'h0000_0100);
    exp_sent(8, 1);
    wb(1'b1, 6'd1, 32'h0000_0000);
    wb(1'b1, 6'd0, 32'h0000_01f7);
    wb(1'b1, 6'd1, 32'h0000_000f);
    exp_sent(1, 1);
    chk("disabled index", 0, scnt[3]);
    wb(1'b1, 6'd48, 32'h0000_0004);
    exp_sent(0, 3);
    wb(1'b1, 6'd48, 32'h0000_01f4);
    wb(1'b1, 6'd1, 32'h0000_0000);
    repeat (20) @(posedge clock);
    n = scnt[0];
    wb(1'b1, 6'd1, 32'h0000_0001);
    exp_sent(0, n + 1);
    wb(1'b1, 6'd4, 32'h0000_0001);
    exp_sent(0, n + 2);
    $display("test transmit done");
    uc = 48'({$urandom, $urandom});
    wb(1'b1, 6'd16, uc[31:0]);
    wb(1'b1, 6'd17, {16'h0000, uc[47:32]});
    wb(1'b1, 6'd25, 32'h8808_0001);
    wb(1'b1, 6'd26, 32'h8808_0101);
    wb(1'b1, 6'd3, 32'h0087_5000);
    wb(1'b1, 6'd2, 32'h0000_03f7);
    rxe.push_back({4'd8, 9'h100, 16'h0040});
    rxf(uc, 16'h0001, 8'h00, 16'h0040);
    @(posedge clock);
    chk("request set", 1'b1, rxr[8]);
    for (int k = 0; k < 40 && rxr[8] !== 1'b0; k++) @(posedge clock);
    chk("request after ack", 1'b0, rxr[8]);
    rxf(uc ^ 48'h1, 16'h0001, 8'h00, 16'h0040);
    rxf(uc, 16'h0002, 8'h00, 16'h0040);
    rxe.push_back({4'd1, 9'h002, 16'h0033});
    rxf(48'h0, 16'h0101, 8'h0a, 16'h0033);
    wb(1'b1, 6'd2, 32'h0000_01f7);
    rxe.push_back({4'd8, 9'h100, 16'h00c8});
    rxf(uc, 16'h0001, 8'h00, 16'h00c8);
    repeat (20) @(posedge clock);
    chk("request held", 1'b1, rxr[8]);
    chk("xoff held", 1'b1, xoff[8]);
    $display("test receive done");
    wb(1'b1, 6'd23, 32'h0010_0008);
    wb(1'b1, 6'd3, 32'h0087_5021);
    wb(1'b1, 6'd2, 32'h0000_05f7);
    n = nfwd;
    for (int k = 7; k < 18; k++)
      rxf(48'h0, 16'(k), 8'h00, 16'h0000);
    repeat (2) @(posedge clock);
    chk("forwarded", n + 9, nfwd);
    wb(1'b1, 6'd2, 32'h0000_01f7);
    n = ndrp;
    rxf(48'h0, 16'h0010, 8'h00, 16'h0000);
    repeat (2) @(posedge clock);
    chk("dropped", n + 1, ndrp);
    n = nsnap;
    pulse();
    wb(1'b1, 6'd2, 32'h0000_09f7);
    pulse();
    wb(1'b1, 6'd4, 32'h0000_0002);
    repeat (3) @(posedge clock);
    chk("snapshots", n + 2, nsnap);
    $display("test control done");
    conclude();
  end
endmodule : pfc_pause_flow_control_bench
`default_nettype wire
